/* File: hdl/ide_drive_timing_config.sv */
// drive 1 pio timing and ultra dma timing configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "ide_timing_regs.svh"

module ide_drive_timing_config
   import ide_timing_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // configuration access
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   // per channel controls, index 0 primary, 1 secondary
   input wire logic [1:0] slaveTimingEnable,
   input wire logic [1:0] drv1FastTimingBank,
   input wire logic [1:0] drv1DataPortAccess,
   // per drive base clocks, index {channel, drive}
   input wire logic [3:0] baseClockSel,
   input wire logic [3:0] fastBaseClock,
   // drive 1 pio timing per channel
   output logic [1:0] slaveTimingActive,
   output clocks_t [1:0] drv1SampleClocks,
   output clocks_t [1:0] drv1RecoveryClocks,
   output logic [1:0] drv1PioReserved,
   // ultra dma per drive, index {channel, drive}
   output logic [3:0] udmaEnable,
   output clocks_t [3:0] strobeCycleTime,
   output stop_clocks_t [3:0] readyToStopInterval,
   output logic [3:0] udmaTimingReserved
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] drive1PioTiming;
      logic [3:0] udmaEnableControl;
      logic [15:0] udmaCycleTiming;
      logic [31:0] rdData;
      logic rdValid;
   } state_s;

   state_s state_reg;
   state_s state_next;

   // apply byte enables to one byte of stored data
   function automatic logic [7:0] merge_byte(input logic [7:0] old,
      input logic [7:0] wr, input logic en);
      merge_byte = en ? wr : old;
   endfunction

   // pio sample point code to clocks
   function automatic pio_timing_s decode_pio(input code_t sp,
      input code_t rc);
      decode_pio.reserved = (sp == 2'b11);
      case (sp)
         2'b00: decode_pio.sampleClocks = `SAMPLE_CLKS_CODE0;
         2'b01: decode_pio.sampleClocks = `SAMPLE_CLKS_CODE1;
         2'b10: decode_pio.sampleClocks = `SAMPLE_CLKS_CODE2;
         default: decode_pio.sampleClocks = 3'h0;
      endcase
      // 00..11 gives 4..1 clocks
      decode_pio.recoveryClocks = `RECOVERY_CLKS_MAX - {1'b0, rc};
   endfunction

   // ultra dma cycle code to clocks for the chosen base clock
   function automatic udma_timing_s decode_udma(input code_t ct,
      input logic base66, input logic fast133);
      decode_udma.cycleClocks = 3'h0;
      decode_udma.stopClocks = 5'h00;
      decode_udma.reserved = 1'b1;
      if (fast133) begin
         if (ct == 2'b01) begin
            decode_udma.cycleClocks = `CT_CLKS_CODE1;
            decode_udma.stopClocks = `RP_133;
            decode_udma.reserved = 1'b0;
         end
      end else if (base66) begin
         case (ct)
            2'b01: begin
               decode_udma.cycleClocks = `CT_CLKS_CODE1;
               decode_udma.stopClocks = `RP_66;
               decode_udma.reserved = 1'b0;
            end
            2'b10: begin
               decode_udma.cycleClocks = `CT_CLKS_CODE2;
               decode_udma.stopClocks = `RP_66;
               decode_udma.reserved = 1'b0;
            end
            default: decode_udma.reserved = 1'b1;
         endcase
      end else begin
         case (ct)
            2'b00: begin
               decode_udma.cycleClocks = `CT_CLKS_CODE0;
               decode_udma.stopClocks = `RP_33_CODE0;
               decode_udma.reserved = 1'b0;
            end
            2'b01: begin
               decode_udma.cycleClocks = `CT_CLKS_CODE1;
               decode_udma.stopClocks = `RP_33_CODE1;
               decode_udma.reserved = 1'b0;
            end
            2'b10: begin
               decode_udma.cycleClocks = `CT_CLKS_CODE2;
               decode_udma.stopClocks = `RP_33_CODE2;
               decode_udma.reserved = 1'b0;
            end
            default: decode_udma.reserved = 1'b1;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   // next state: byte-enabled writes, registered read data
   always_comb begin
      state_next = state_reg;
      state_next.rdValid = cfgRead;
      if (cfgWrite && cfgAddr == `DRIVE1_PIO_TIMING_OFS) begin
         state_next.drive1PioTiming = merge_byte(state_reg.drive1PioTiming,
            cfgWrData[7:0], cfgByteEn[0]);
      end
      if (cfgWrite && cfgAddr == `UDMA_DWORD_OFS) begin
         if (cfgByteEn[0]) begin
            state_next.udmaEnableControl = cfgWrData[3:0];
         end
         state_next.udmaCycleTiming[7:0] = merge_byte(
            state_reg.udmaCycleTiming[7:0],
            cfgWrData[23:16] & `CYCLE_TIME_BYTE_MASK,
            cfgByteEn[2]);
         state_next.udmaCycleTiming[15:8] = merge_byte(
            state_reg.udmaCycleTiming[15:8],
            cfgWrData[31:24] & `CYCLE_TIME_BYTE_MASK, cfgByteEn[3]);
      end
      if (cfgRead) begin
         case (cfgAddr)
            `DRIVE1_PIO_TIMING_OFS:
               state_next.rdData = {24'h000000, state_reg.drive1PioTiming};
            `UDMA_DWORD_OFS:
               state_next.rdData = {state_reg.udmaCycleTiming, 12'h000,
                  state_reg.udmaEnableControl};
            default: state_next.rdData = 32'h00000000; // unmapped
         endcase
      end
   end

   // state register, cleared to zero at reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cfgRdData = state_reg.rdData;
   assign cfgRdValid = state_reg.rdValid;

   // ----------------------------------------------------------------
   // decoded timing
   // ----------------------------------------------------------------
   pio_timing_s pioDec [2];
   udma_timing_s udmaDec [4];

   // per channel drive 1 pio timing
   assign pioDec[0] = decode_pio(
      state_reg.drive1PioTiming[`PRI_DRV1_SAMPLE_POINT_LSB +: 2],
      state_reg.drive1PioTiming[`PRI_DRV1_RECOVERY_LSB +: 2]);
   assign pioDec[1] = decode_pio(
      state_reg.drive1PioTiming[`SEC_DRV1_SAMPLE_POINT_LSB +: 2],
      state_reg.drive1PioTiming[`SEC_DRV1_RECOVERY_LSB +: 2]);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_chan
         // slave timing used only on drive 1 data port with bit 14 set
         assign slaveTimingActive[g] = drv1DataPortAccess[g] &
            slaveTimingEnable[g] & drv1FastTimingBank[g];
         assign drv1SampleClocks[g] = pioDec[g].sampleClocks;
         assign drv1RecoveryClocks[g] = pioDec[g].recoveryClocks;
         assign drv1PioReserved[g] = pioDec[g].reserved;
      end
      for (g = 0; g < 4; g++) begin : gen_drive
         // field g sits at bit 4*g; index 3 sec drv1, 2 sec drv0
         assign udmaDec[g] = decode_udma(
            state_reg.udmaCycleTiming[4*g +: 2], baseClockSel[g],
            fastBaseClock[g]);
         assign udmaEnable[g] = state_reg.udmaEnableControl[g];
         assign strobeCycleTime[g] = udmaDec[g].cycleClocks;
         assign readyToStopInterval[g] = udmaDec[g].stopClocks;
         assign udmaTimingReserved[g] = udmaDec[g].reserved;
      end
   endgenerate

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sec_sample_pt_a: assert property (
      cfgWrite && cfgAddr == 8'h44 && cfgByteEn[0] && cfgWrData[7:6] == 2'b00
      |=> drv1SampleClocks[1] == 3'h5)
      else $error("secondary sample point not 5 clocks");
   slave_select_a: assert property (
      !slaveTimingEnable[1] |-> !slaveTimingActive[1])
      else $error("slave timing active without bit 14");
   sec_recovery_a: assert property (
      drv1RecoveryClocks[1] + 3'(state_reg.drive1PioTiming[5:4]) == 3'h4
      && drv1RecoveryClocks[1] != 3'h0)
      else $error("secondary recovery wrong");
   pri_sample_pt_a: assert property (
      cfgWrite && cfgAddr == 8'h44 && cfgByteEn[0] && cfgWrData[3:2] == 2'b10
      |=> drv1SampleClocks[0] == 3'h3 && !drv1PioReserved[0])
      else $error("primary sample point not 3 clocks");
   pri_recovery_a: assert property (
      state_reg.drive1PioTiming[1:0] == 2'b11
      |-> drv1RecoveryClocks[0] == 3'h1)
      else $error("primary recovery not 1 clock");
   udma_enable_a: assert property (
      cfgWrite && cfgAddr == 8'h48 && cfgByteEn[0]
      |=> udmaEnable == $past(cfgWrData[3:0]))
      else $error("ultra dma enable not written");
   udma_hold_a: assert property (
      !(cfgWrite && cfgAddr == 8'h48) |=> $stable(udmaEnable))
      else $error("ultra dma enable changed without write");
   sec1_cycle_a: assert property (
      cfgWrite && cfgAddr == 8'h48 && cfgByteEn[3] && cfgWrData[29:28] == 2'b01
      ##1 !baseClockSel[3] && !fastBaseClock[3]
      |-> strobeCycleTime[3] == 3'h3 && readyToStopInterval[3] == 5'h05)
      else $error("secondary drive 1 cycle time wrong");
   base33_a: assert property (
      !baseClockSel[2] && !fastBaseClock[2]
      && state_reg.udmaCycleTiming[9:8] == 2'b00
      |-> strobeCycleTime[2] == 3'h4 && readyToStopInterval[2] == 5'h06)
      else $error("33 MHz code 00 wrong");
   base66_a: assert property (
      baseClockSel[0] && !fastBaseClock[0]
      |-> udmaTimingReserved[0] || readyToStopInterval[0] == 5'h08)
      else $error("66 MHz stop interval not 8");
   fast133_a: assert property (
      fastBaseClock[1] |-> (udmaTimingReserved[1] ==
      (state_reg.udmaCycleTiming[5:4] != 2'b01)) &&
      (udmaTimingReserved[1] || readyToStopInterval[1] == 5'h10))
      else $error("133 MHz timing wrong");
   read_lat_a: assert property (
      cfgRead && cfgAddr == 8'h48 |=> cfgRdValid &&
      cfgRdData[27:24] == $past(state_reg.udmaCycleTiming[11:8]))
      else $error("cycle timing read back wrong");

   cov_slave_c: cover property (slaveTimingActive[1] && !drv1PioReserved[1]);
   cov_fast_c: cover property (fastBaseClock[3] && !udmaTimingReserved[3]);
   cov_read_c: cover property (cfgRead ##1 cfgRdValid && cfgRdData != 32'h0);
   cov_udma_c: cover property (udmaEnable == 4'hf);

endmodule

`default_nettype wire

/* File: hdl/ide_timing_regs.svh */
// offsets, field positions, reset values and timing codes of the block
`ifndef IDE_TIMING_REGS_SVH
`define IDE_TIMING_REGS_SVH

// ----------------------------------------------------------------
// configuration offsets (byte addresses)
// ----------------------------------------------------------------
`define DRIVE1_PIO_TIMING_OFS 8'h44
`define UDMA_ENABLE_CONTROL_OFS 8'h48
`define UDMA_CYCLE_TIMING_OFS 8'h4a
`define UDMA_DWORD_OFS 8'h48

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DRIVE1_PIO_TIMING_RST 8'h00
`define UDMA_ENABLE_CONTROL_RST 4'h0
`define UDMA_CYCLE_TIMING_RST 16'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEC_DRV1_SAMPLE_POINT_LSB 6
`define SEC_DRV1_RECOVERY_LSB 4
`define PRI_DRV1_SAMPLE_POINT_LSB 2
`define PRI_DRV1_RECOVERY_LSB 0
`define UDMA_ENABLE_WIDTH 4
`define SEC_DRV1_CYCLE_TIME_LSB 12
`define SEC_DRV0_CYCLE_TIME_LSB 8
`define PRI_DRV1_CYCLE_TIME_LSB 4
`define PRI_DRV0_CYCLE_TIME_LSB 0
`define CYCLE_TIME_FIELDS_MASK 16'h3333
`define CYCLE_TIME_BYTE_MASK 8'h33

// ----------------------------------------------------------------
// timing counts in PCI clocks
// ----------------------------------------------------------------
`define SAMPLE_CLKS_CODE0 3'h5
`define SAMPLE_CLKS_CODE1 3'h4
`define SAMPLE_CLKS_CODE2 3'h3
`define RECOVERY_CLKS_MAX 3'h4
`define CT_CLKS_CODE0 3'h4
`define CT_CLKS_CODE1 3'h3
`define CT_CLKS_CODE2 3'h2
`define RP_33_CODE0 5'h06
`define RP_33_CODE1 5'h05
`define RP_33_CODE2 5'h04
`define RP_66 5'h08
`define RP_133 5'h10

`endif

/* File: hdl/ide_timing_pkg.sv */
// types shared by the drive timing configuration block
package ide_timing_pkg;
   typedef logic [1:0] code_t;
   typedef logic [2:0] clocks_t;
   typedef logic [4:0] stop_clocks_t;
   // decoded ultra dma timing of one drive
   typedef struct packed {
      clocks_t cycleClocks;
      stop_clocks_t stopClocks;
      logic reserved;
   } udma_timing_s;
   // decoded pio timing of one drive 1
   typedef struct packed {
      clocks_t sampleClocks;
      clocks_t recoveryClocks;
      logic reserved;
   } pio_timing_s;
endpackage

/* File: sim/drive_side_model.sv */
// behavioural channel and drive side feeding the per drive control levels
`timescale 1ns/100ps
`default_nettype none

module drive_side_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // requested state, index 0 primary, 1 secondary; base and fast index {channel, drive}
   input wire logic [1:0] portReq,
   input wire logic [1:0] bankReq,
   input wire logic [1:0] timingReq,
   input wire logic [3:0] baseReq,
   input wire logic [3:0] fastReq,
   // levels presented to the timing block
   output logic [1:0] slaveTimingEnable,
   output logic [1:0] drv1FastTimingBank,
   output logic [1:0] drv1DataPortAccess,
   output logic [3:0] baseClockSel,
   output logic [3:0] fastBaseClock
);
   // levels move only just after an edge, all low in reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slaveTimingEnable <= 2'h0;
         drv1FastTimingBank <= 2'h0;
         drv1DataPortAccess <= 2'h0;
         baseClockSel <= 4'h0;
         fastBaseClock <= 4'h0;
      end else begin
         slaveTimingEnable <= timingReq;
         drv1FastTimingBank <= bankReq;
         drv1DataPortAccess <= portReq;
         baseClockSel <= baseReq;
         fastBaseClock <= fastReq;
      end
   end
endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the drive timing configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "ide_timing_regs.svh"

module tb_top;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cfgWrite = 1'b0;
   logic cfgRead = 1'b0;
   logic [7:0] cfgAddr = 8'h00;
   logic [3:0] cfgByteEn = 4'h0;
   logic [31:0] cfgWrData = 32'h0;
   logic [1:0] portReq = 2'h0;
   logic [1:0] bankReq = 2'h0;
   logic [1:0] timingReq = 2'h0;
   logic [3:0] baseReq = 4'h0;
   logic [3:0] fastReq = 4'h0;
   logic [31:0] cfgRdData, rd;
   logic cfgRdValid;
   logic [1:0] slaveTimingEnable, drv1FastTimingBank, drv1DataPortAccess;
   logic [1:0] slaveTimingActive, drv1PioReserved;
   logic [3:0] baseClockSel, fastBaseClock, udmaEnable, udmaTimingReserved;
   logic [1:0][2:0] drv1SampleClocks, drv1RecoveryClocks;
   logic [3:0][2:0] strobeCycleTime;
   logic [3:0][4:0] readyToStopInterval;
   logic [8:0] eu;
   int miscompares = 0;
   int checks = 0;

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   drive_side_model i_drives (.ref_clk(ref_clk), .reset_n(reset_n),
      .portReq(portReq), .bankReq(bankReq), .timingReq(timingReq),
      .baseReq(baseReq), .fastReq(fastReq),
      .slaveTimingEnable(slaveTimingEnable),
      .drv1FastTimingBank(drv1FastTimingBank),
      .drv1DataPortAccess(drv1DataPortAccess),
      .baseClockSel(baseClockSel), .fastBaseClock(fastBaseClock));

   ide_drive_timing_config i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
      .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
      .slaveTimingEnable(slaveTimingEnable),
      .drv1FastTimingBank(drv1FastTimingBank),
      .drv1DataPortAccess(drv1DataPortAccess),
      .baseClockSel(baseClockSel), .fastBaseClock(fastBaseClock),
      .slaveTimingActive(slaveTimingActive),
      .drv1SampleClocks(drv1SampleClocks),
      .drv1RecoveryClocks(drv1RecoveryClocks),
      .drv1PioReserved(drv1PioReserved), .udmaEnable(udmaEnable),
      .strobeCycleTime(strobeCycleTime),
      .readyToStopInterval(readyToStopInterval),
      .udmaTimingReserved(udmaTimingReserved));

   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // one access cycle; a read also checks the one cycle valid pulse
   task automatic acc(input logic w, input logic r, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      @(posedge ref_clk);
      cfgWrite <= w;
      cfgRead <= r;
      cfgAddr <= a;
      cfgByteEn <= be;
      cfgWrData <= d;
      @(posedge ref_clk);
      cfgWrite <= 1'b0;
      cfgRead <= 1'b0;
      @(negedge ref_clk);
      if (r) begin
         chk(cfgRdValid, 32'h1);
         rd = cfgRdData;
         @(negedge ref_clk);
         chk(cfgRdValid, 32'h0);
      end
   endtask

   // expected {reserved, cycle, stop} for base mode and code
   function automatic logic [8:0] ud(input int m, input int c);
      if (m == 0 && c < 3) return {1'b0, 3'(3'h4 - c), 5'(5'h06 - c)};
      if (m == 1 && (c == 1 || c == 2)) return {1'b0, 3'(3'h4 - c), 5'h08};
      if (m == 2 && c == 1) return {1'b0, 3'h3, 5'h10};
      return 9'h100;
   endfunction

   // drives whose base mode in pass m is k or above
   function automatic logic [3:0] modes(input int m, input int k);
      for (int d = 0; d < 4; d++) begin
         modes[d] = ((m + d) % 3) >= k;
      end
   endfunction

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      chk({drv1SampleClocks, drv1RecoveryClocks}, 32'hb64);
      chk(udmaEnable, 32'h0);
      acc(1'b0, 1'b1, `DRIVE1_PIO_TIMING_OFS, 4'h0, 32'h0);
      chk(rd, 32'h0);
      acc(1'b0, 1'b1, `UDMA_DWORD_OFS, 4'h0, 32'h0);
      chk(rd, 32'h0);
      // every sample point and recovery code on both channels
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, 1'b0, `DRIVE1_PIO_TIMING_OFS, 4'h1, 32'(c * 8'h55));
         chk(drv1SampleClocks[1], (c == 3) ? 32'h0 : 32'(5 - c));
         chk(drv1SampleClocks[0], (c == 3) ? 32'h0 : 32'(5 - c));
         chk(drv1RecoveryClocks[1], 32'(4 - c));
         chk(drv1RecoveryClocks[0], 32'(4 - c));
         chk(drv1PioReserved, (c == 3) ? 32'h3 : 32'h0);
         acc(1'b0, 1'b1, `DRIVE1_PIO_TIMING_OFS, 4'h0, 32'h0);
         chk(rd, 32'(c * 8'h55));
      end
      // read and write together return the old value
      acc(1'b1, 1'b1, `DRIVE1_PIO_TIMING_OFS, 4'h1, 32'h1b);
      chk(rd, 32'hff);
      // drive 1 timing applies only with port, bank and enable set
      for (int i = 0; i < 64; i++) begin
         @(posedge ref_clk);
         portReq <= 2'(i);
         bankReq <= 2'(i >> 2);
         timingReq <= 2'(i >> 4);
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(slaveTimingActive, 32'(i & (i >> 2) & (i >> 4) & 3));
      end
      // enable bits, byte lanes and reserved bits
      acc(1'b1, 1'b0, `UDMA_DWORD_OFS, 4'h1, 32'h0000_000f);
      chk(udmaEnable, 32'hf);
      acc(1'b1, 1'b0, `UDMA_DWORD_OFS, 4'h1, 32'hffff_fff5);
      chk(udmaEnable, 32'h5);
      acc(1'b1, 1'b0, `UDMA_DWORD_OFS, 4'h1, 32'h0000_000a);
      chk(udmaEnable, 32'ha);
      acc(1'b1, 1'b0, `UDMA_DWORD_OFS, 4'h0, 32'hffff_ffff);
      acc(1'b1, 1'b0, `UDMA_DWORD_OFS, 4'hc, 32'hffff_ffff);
      acc(1'b0, 1'b1, `UDMA_DWORD_OFS, 4'h0, 32'h0);
      chk(rd, 32'h3333_000a);
      // unmapped place ignores writes and reads zero
      acc(1'b1, 1'b0, 8'h50, 4'hf, 32'hffff_ffff);
      acc(1'b0, 1'b1, 8'h50, 4'h0, 32'h0);
      chk(rd, 32'h0);
      acc(1'b0, 1'b1, `DRIVE1_PIO_TIMING_OFS, 4'h0, 32'h0);
      chk(rd, 32'h1b);
      // every cycle code under each base clock, fast overriding base
      for (int m = 0; m < 3; m++) begin
         @(posedge ref_clk);
         baseReq <= modes(m, 1);
         fastReq <= modes(m, 2);
         for (int c = 0; c < 4; c++) begin
            // every field gets its own code to expose swapped fields
            acc(1'b1, 1'b0, `UDMA_DWORD_OFS, 4'hc,
               {16'(((c + 3) % 4) << 12 | ((c + 2) % 4) << 8 |
               ((c + 1) % 4) << 4 | c), 16'h0});
            for (int d = 0; d < 4; d++) begin
               eu = ud((m + d) % 3, (c + d) % 4);
               chk(strobeCycleTime[d], 32'(eu[7:5]));
               chk(readyToStopInterval[d], 32'(eu[4:0]));
               chk(udmaTimingReserved[d], 32'(eu[8]));
            end
         end
      end
      // reset in mid run clears every register
      @(posedge ref_clk);
      reset_n <= 1'b0;
      @(negedge ref_clk);
      chk(udmaEnable, 32'h0);
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      acc(1'b0, 1'b1, `UDMA_DWORD_OFS, 4'h0, 32'h0);
      chk(rd, 32'h0);
      acc(1'b0, 1'b1, `DRIVE1_PIO_TIMING_OFS, 4'h0, 32'h0);
      chk(rd, 32'h0);
      tally_and_finish();
   end
endmodule

`default_nettype wire
